// ==== vcsc_core.sv ====
// Top of the voice codec serial core: host side, clock divider and crossings
`default_nettype none
// Overview of operation
// - Drive a 4 MHz master clock out
// - Default frame rate 8 kHz, one sample each way
// - Sample codec data line into received word
// - Shift outgoing word onto codec data line
// - Only serial mode zero framing is supported
// - Pulse interrupt on receive or transmit completion
// - Async low reset clears all state but the buffer storage at once
// - Sync high reset clears state next edge
// - Take 16-bit sample, acknowledge after transmission
// - Pulse once per fully processed frame
// - Present latest received sample to host
// - Output frame sync synchronised to system clock
// - Master clock runs only when enabled
// - Outgoing word LSB is a codec control flag
// - LSB one requests a secondary frame next
module vcsc_core
	import vcsc_pkg::*;
(
	// System clock and resets
	input  wire logic                   sys_clk,
	input  wire logic                   reset_n,
	input  wire logic                   sync_reset,
	// Control
	input  wire logic                   mclk_enable,
	input  wire logic                   codec_enable,
	// Outgoing samples
	input  wire logic [vcsc_pkg::VCSC_WORD_W-1:0] write_data,
	input  wire logic                   write_valid,
	output logic                        write_ready,
	output logic                        write_data_grasp,
	output logic                        write_busy,
	// Incoming samples and events
	output logic [vcsc_pkg::VCSC_WORD_W-1:0] read_data,
	output logic                        read_valid,
	output logic                        done,
	output logic                        sample_irq,
	// Codec pins
	input  wire logic                   codec_serial_in_pin,
	output logic                        codec_serial_out_pin,
	input  wire logic                   codec_bit_clock_pin,
	input  wire logic                   codec_frame_sync_pin,
	output logic                        codec_master_clock_pin,
	output logic                        fsync_out
);
	import vcsc_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	vcsc_tx_state_e        tx_state;      // Outgoing handshake state
	logic [VCSC_ACC_W-1:0] mclk_acc;      // Divider phase
	logic [VCSC_ACC_W-1:0] next_mclk_acc; // Divider phase after this cycle
	logic                  mclk_run;      // Divider allowed to run
	logic [VCSC_HOLD_W-1:0] hold_cnt;     // Link hold stretch
	logic                  hold;          // Link held in reset
	logic [15:0]           tx_word;       // Word offered to the link
	logic                  tx_req_tgl;    // Flips for every offered word
	logic [15:0]           fifo_data;     // Oldest buffered sample
	logic                  fifo_valid;    // Buffer not empty
	logic                  fifo_pop;      // Buffer drained this cycle
	logic [15:0]           link_rx_word;  // Received word, stable per frame
	logic                  link_frame_tgl;
	logic                  link_sent_tgl;
	logic                  frame_meta;    // First stage, read only by the second
	logic                  frame_sync;
	logic                  frame_prev;
	logic                  sent_meta;     // First stage, read only by the second
	logic                  sent_sync;
	logic                  sent_prev;
	logic                  fs_meta;       // First stage, read only by the second
	logic                  fs_sync;
	logic                  frame_evt;     // Frame finished at the link
	logic                  sent_evt;      // Host word left the link

	// ****************************************
	// Outgoing sample buffer
	// ****************************************
	// Host stalls on write_ready once eight samples wait
	vcsc_fifo #(
		.WIDTH (VCSC_WORD_W),
		.DEPTH (VCSC_FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.clear     (sync_reset),
		.in_data   (write_data),
		.in_valid  (write_valid),
		.in_ready  (write_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	// ****************************************
	// Link domain
	// ****************************************
	// Only mode zero framing exists here: low frame sync, sixteen bits, MSB first
	vcsc_link u_link (
		.link_clk     (codec_bit_clock_pin),
		.reset_n      (reset_n),
		.hold         (hold),
		.tx_word      (tx_word),
		.tx_req_tgl   (tx_req_tgl),
		.rx_word      (link_rx_word),
		.frame_tgl    (link_frame_tgl),
		.sent_tgl     (link_sent_tgl),
		.serial_in    (codec_serial_in_pin),
		.frame_sync_n (codec_frame_sync_pin),
		.serial_out   (codec_serial_out_pin)
	);

	// ****************************************
	// Link hold
	// ****************************************
	// A one-cycle reset is far shorter than a bit period, so it is stretched
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_cnt <= VCSC_HOLD_LOAD;
			hold     <= 1'b1;
		end else if (sync_reset) begin
			hold_cnt <= VCSC_HOLD_LOAD;
			hold     <= 1'b1;
		end else if (!codec_enable) begin
			hold_cnt <= VCSC_HOLD_LOAD;
			hold     <= 1'b1;
		end else if (hold_cnt != VCSC_HOLD_RST) begin
			hold_cnt <= hold_cnt - 8'h01;
			hold     <= 1'b1;
		end else begin
			hold <= 1'b0;
		end
	end

	// ****************************************
	// Master clock divider
	// ****************************************
	// 100 MHz over 4 MHz is an odd 25 cycles, so duty is 13 high, 12 low
	assign mclk_run = mclk_enable && codec_enable;

	always_comb begin
		next_mclk_acc = mclk_acc + VCSC_ACC_STEP;
		if (next_mclk_acc >= VCSC_ACC_MOD) begin
			next_mclk_acc = next_mclk_acc - VCSC_ACC_MOD;
		end
	end

	// Phase held at zero while stopped so restart is clean
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mclk_acc               <= VCSC_ACC_RST;
			codec_master_clock_pin <= 1'b0;
		end else if (sync_reset || !mclk_run) begin
			mclk_acc               <= VCSC_ACC_RST;
			codec_master_clock_pin <= 1'b0;
		end else begin
			mclk_acc               <= next_mclk_acc;
			codec_master_clock_pin <= (mclk_acc < VCSC_ACC_HALF);
		end
	end

	// ****************************************
	// Crossings into the system domain
	// ****************************************
	// Frame sync and link toggles pass two stages before any logic
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_meta <= 1'b0;
			frame_sync <= 1'b0;
			frame_prev <= 1'b0;
			sent_meta  <= 1'b0;
			sent_sync  <= 1'b0;
			sent_prev  <= 1'b0;
			fs_meta    <= 1'b1;
			fs_sync    <= 1'b1;
			fsync_out  <= 1'b1;
		end else begin
			frame_meta <= link_frame_tgl;
			frame_sync <= frame_meta;
			frame_prev <= frame_sync;
			sent_meta  <= link_sent_tgl;
			sent_sync  <= sent_meta;
			sent_prev  <= sent_sync;
			fs_meta    <= codec_frame_sync_pin;
			fs_sync    <= fs_meta;
			fsync_out  <= fs_sync;
		end
	end

	// Events ignored while the link is held, as it clears its toggles then
	assign frame_evt = vcsc_toggle_seen(frame_sync, frame_prev) && !hold;
	assign sent_evt  = vcsc_toggle_seen(sent_sync, sent_prev) && !hold;

	// ****************************************
	// Outgoing handshake
	// ****************************************
	// Buffer drains only when the link has no word outstanding
	assign fifo_pop = (tx_state == VCSC_TX_IDLE) && fifo_valid && !hold;

	// Word and LSB go out as given; LSB one asks the codec for a register frame
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_state         <= VCSC_TX_IDLE;
			tx_word          <= VCSC_WORD_RST;
			tx_req_tgl       <= 1'b0;
			write_data_grasp <= 1'b0;
			write_busy       <= 1'b0;
		end else if (sync_reset) begin
			tx_state         <= VCSC_TX_IDLE;
			tx_word          <= VCSC_WORD_RST;
			tx_req_tgl       <= 1'b0;
			write_data_grasp <= 1'b0;
			write_busy       <= 1'b0;
		end else begin
			write_data_grasp <= 1'b0;
			case (tx_state)
				VCSC_TX_IDLE: begin
					if (fifo_pop) begin
						tx_word    <= fifo_data;
						tx_req_tgl <= ~tx_req_tgl;
						tx_state   <= VCSC_TX_WAIT;
						write_busy <= 1'b1;
					end
				end
				VCSC_TX_WAIT: begin
					if (hold) begin
						// Link cleared, word is dropped without acknowledge
						tx_state   <= VCSC_TX_IDLE;
						write_busy <= 1'b0;
					end else if (sent_evt) begin
						write_data_grasp <= 1'b1;
						tx_state         <= VCSC_TX_IDLE;
						write_busy       <= 1'b0;
					end
				end
				default: begin
					tx_state   <= VCSC_TX_IDLE;
					write_busy <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Received samples and frame events
	// ****************************************
	// One frame of the 8 kHz stream gives one sample each way
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			read_data  <= VCSC_WORD_RST;
			read_valid <= 1'b0;
			done       <= 1'b0;
			sample_irq <= 1'b0;
		end else if (sync_reset) begin
			read_data  <= VCSC_WORD_RST;
			read_valid <= 1'b0;
			done       <= 1'b0;
			sample_irq <= 1'b0;
		end else begin
			read_valid <= frame_evt;
			done       <= frame_evt;
			sample_irq <= frame_evt || (sent_evt && tx_state == VCSC_TX_WAIT);
			if (frame_evt) begin
				read_data <= link_rx_word;
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	// Cycles since the master clock last rose; zero while stopped or not yet seen
	// A counter stands in for long repetitions, which the tools unroll slowly
	logic [4:0] mclk_age;  // Zero means not counting
	logic       mclk_prev; // Pin level one cycle ago
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mclk_age  <= 5'h00;
			mclk_prev <= 1'b0;
		end else begin
			mclk_prev <= codec_master_clock_pin;
			if (sync_reset || !mclk_run) begin
				mclk_age <= 5'h00;
			end else if (codec_master_clock_pin && !mclk_prev) begin
				mclk_age <= 5'h01;
			end else if (mclk_age != 5'h00 && mclk_age != 5'h1F) begin
				mclk_age <= mclk_age + 5'h01;
			end
		end
	end

	a_done_single: assert property (@(posedge sys_clk) disable iff (!reset_n)
		done |=> !done)
		else $error("done pulse lasted more than one cycle");

	a_grasp_after_wait: assert property (@(posedge sys_clk) disable iff (!reset_n)
		write_data_grasp |-> $past(tx_state) == VCSC_TX_WAIT && !write_busy)
		else $error("acknowledge without an outstanding word");

	a_irq_cause: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sample_irq == (done || write_data_grasp))
		else $error("interrupt pulse not tied to receive or transmit");

	a_mclk_stopped: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!mclk_run |=> !codec_master_clock_pin)
		else $error("master clock ran while disabled");

	a_mclk_high_time: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$fell(codec_master_clock_pin) && mclk_age != 5'h00
			|-> mclk_age == 5'((VCSC_ACC_HALF + VCSC_ACC_STEP - 7'h01) / VCSC_ACC_STEP))
		else $error("master clock high phase is not 13 cycles");

	a_mclk_period: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(codec_master_clock_pin) && mclk_age != 5'h00
			|-> mclk_age == 5'(VCSC_ACC_MOD / VCSC_ACC_STEP))
		else $error("master clock period is not 25 cycles");

	a_fsync_delay: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$past(reset_n, 3) |-> fsync_out == $past(fs_sync))
		else $error("frame sync copy not one stage behind the synchroniser");

	a_read_on_done: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!$stable(read_data) |-> done || $past(sync_reset))
		else $error("received sample changed outside a frame event");

	a_word_stable: assert property (@(posedge sys_clk) disable iff (!reset_n)
		tx_state == VCSC_TX_WAIT && $past(tx_state) == VCSC_TX_WAIT |-> $stable(tx_word))
		else $error("outgoing word changed while the link may read it");

	a_sync_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sync_reset |=> !done && !write_data_grasp && !write_busy && hold
			&& !codec_master_clock_pin)
		else $error("synchronous reset did not clear state");

endmodule
`default_nettype wire

// ==== vcsc_pkg.sv ====
// Shared constants, types and helpers of the voice codec serial core
`default_nettype none
package vcsc_pkg;

	// ****************************************
	// Clock rates and divider
	// ****************************************
	localparam int VCSC_SYS_CLK_KHZ = 100000;      // System clock rate
	localparam int VCSC_MCLK_KHZ    = 4000;        // Master clock toward the codec
	localparam int VCSC_BCLK_KHZ    = 2048;        // Bit clock the codec returns
	localparam int VCSC_FRAME_KHZ   = 8;           // Frame and sample rate
	localparam int VCSC_FRAME_BITS  = VCSC_BCLK_KHZ / VCSC_FRAME_KHZ;
	localparam int VCSC_ACC_W       = 7;           // Phase accumulator width
	localparam logic [VCSC_ACC_W-1:0] VCSC_ACC_MOD  = VCSC_ACC_W'(VCSC_SYS_CLK_KHZ / 1000);
	localparam logic [VCSC_ACC_W-1:0] VCSC_ACC_STEP = VCSC_ACC_W'(VCSC_MCLK_KHZ / 1000);
	localparam logic [VCSC_ACC_W-1:0] VCSC_ACC_HALF = VCSC_ACC_W'(VCSC_SYS_CLK_KHZ / 2000);
	localparam logic [VCSC_ACC_W-1:0] VCSC_ACC_RST  = 7'h00;

	// ****************************************
	// Link hold after a synchronous reset
	// ****************************************
	localparam int VCSC_HOLD_NS     = 1500;        // Covers three bit clock periods
	localparam int VCSC_HOLD_CYCLES = (VCSC_HOLD_NS * (VCSC_SYS_CLK_KHZ / 1000) + 999) / 1000;
	localparam int VCSC_HOLD_W      = 8;
	localparam logic [VCSC_HOLD_W-1:0] VCSC_HOLD_LOAD = VCSC_HOLD_W'(VCSC_HOLD_CYCLES);
	localparam logic [VCSC_HOLD_W-1:0] VCSC_HOLD_RST  = 8'h00;

	// ****************************************
	// Word and framing
	// ****************************************
	localparam int VCSC_WORD_W     = 16;           // Sample width
	localparam int VCSC_FIFO_DEPTH = 8;            // Outgoing sample buffer depth
	localparam logic [4:0]  VCSC_WORD_BITS = 5'h10; // Bits shifted per frame
	localparam logic [4:0]  VCSC_LAST_BIT  = 5'h0F; // Index of the final bit
	localparam logic [4:0]  VCSC_CNT_RST   = 5'h00;
	localparam logic [15:0] VCSC_WORD_RST  = 16'h0000;

	// Outgoing handshake states
	typedef enum logic [1:0] {
		VCSC_TX_IDLE = 2'b01,
		VCSC_TX_WAIT = 2'b10
	} vcsc_tx_state_e;

	// Event seen on a synchronised toggle
	function automatic logic vcsc_toggle_seen(input logic now_v, input logic prev_v);
		return now_v ^ prev_v;
	endfunction

endpackage
`default_nettype wire

// ==== vcsc_fifo.sv ====
// Parameterised first-in first-out buffer with valid and ready on both sides
`default_nettype none
module vcsc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic             clear,
	// Filling side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// Draining side
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];    // Storage words
	logic [PW-1:0]    wr_ptr;         // Next slot to fill
	logic [PW-1:0]    rd_ptr;         // Oldest slot
	logic [CW-1:0]    count;          // Words held
	logic [CW-1:0]    next_count;     // Count after this cycle
	logic             do_push;
	logic             do_pop;

	assign do_push  = in_valid && in_ready;
	assign do_pop   = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	// Count moves by one at most
	always_comb begin
		next_count = count;
		if (do_push && !do_pop) begin
			next_count = count + CW'(1);
		end else if (do_pop && !do_push) begin
			next_count = count - CW'(1);
		end
	end

	// Storage written only on an accepted push
	always_ff @(posedge sys_clk) begin
		if (do_push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers, count and registered flags
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else if (clear) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (do_push) begin
				wr_ptr <= wr_ptr + PW'(1);
			end
			if (do_pop) begin
				rd_ptr <= rd_ptr + PW'(1);
			end
			count     <= next_count;
			// Flags registered so full and empty are honest next cycle
			in_ready  <= (next_count != CW'(DEPTH));
			out_valid <= (next_count != '0);
		end
	end
endmodule
`default_nettype wire

// ==== vcsc_link.sv ====
// Bit clock domain shifter that frames one word each way per codec frame
`default_nettype none
module vcsc_link
	import vcsc_pkg::*;
(
	// Link clock and reset
	input  wire logic        link_clk,
	input  wire logic        reset_n,
	input  wire logic        hold,
	// Word exchange with the system side
	input  wire logic [15:0] tx_word,
	input  wire logic        tx_req_tgl,
	output logic [15:0]      rx_word,
	output logic             frame_tgl,
	output logic             sent_tgl,
	// Codec pins, launched and sampled on the codec's own clock
	input  wire logic        serial_in,
	input  wire logic        frame_sync_n,
	output logic             serial_out
);
	logic        hold_meta;   // First stage, read only by the second
	logic        hold_sync;   // Hold level in this domain
	logic        req_meta;    // First stage, read only by the second
	logic        req_sync;    // Request toggle in this domain
	logic        taken;       // Last request toggle taken
	logic        sent_pend;   // Word of this frame came from the host
	logic [4:0]  bit_cnt;     // Bits shifted this frame
	logic [15:0] shift_in;    // Incoming bits
	logic [15:0] shift_out;   // Outgoing bits left

	// ****************************************
	// Crossings into the link domain
	// ****************************************
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_meta <= 1'b1;
			hold_sync <= 1'b1;
			req_meta  <= 1'b0;
			req_sync  <= 1'b0;
		end else begin
			hold_meta <= hold;
			hold_sync <= hold_meta;
			req_meta  <= tx_req_tgl;
			req_sync  <= req_meta;
		end
	end

	// ****************************************
	// Frame shifter
	// ****************************************
	// Every low frame is handled alike, so a secondary frame is just the next word
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt    <= VCSC_CNT_RST;
			shift_in   <= VCSC_WORD_RST;
			shift_out  <= VCSC_WORD_RST;
			rx_word    <= VCSC_WORD_RST;
			serial_out <= 1'b0;
			frame_tgl  <= 1'b0;
			sent_tgl   <= 1'b0;
			taken      <= 1'b0;
			sent_pend  <= 1'b0;
		end else if (hold_sync) begin
			bit_cnt    <= VCSC_CNT_RST;
			shift_in   <= VCSC_WORD_RST;
			shift_out  <= VCSC_WORD_RST;
			rx_word    <= VCSC_WORD_RST;
			serial_out <= 1'b0;
			frame_tgl  <= 1'b0;
			sent_tgl   <= 1'b0;
			taken      <= 1'b0;
			sent_pend  <= 1'b0;
		end else if (!frame_sync_n && bit_cnt != VCSC_WORD_BITS) begin
			bit_cnt  <= bit_cnt + 5'h01;
			shift_in <= {shift_in[14:0], serial_in};
			if (bit_cnt == VCSC_CNT_RST) begin
				// Fresh word only when a new request waits; else send zero
				if (req_sync != taken) begin
					taken      <= req_sync;
					sent_pend  <= 1'b1;
					serial_out <= tx_word[15];
					shift_out  <= {tx_word[14:0], 1'b0};
				end else begin
					serial_out <= 1'b0;
					shift_out  <= VCSC_WORD_RST;
				end
			end else begin
				serial_out <= shift_out[15];
				shift_out  <= {shift_out[14:0], 1'b0};
			end
			if (bit_cnt == VCSC_LAST_BIT) begin
				// Word held stable for the rest of the frame
				rx_word   <= {shift_in[14:0], serial_in};
				frame_tgl <= ~frame_tgl;
				if (sent_pend) begin
					sent_tgl  <= ~sent_tgl;
					sent_pend <= 1'b0;
				end
			end
		end else if (frame_sync_n) begin
			bit_cnt    <= VCSC_CNT_RST;
			serial_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== vcsc_codec_model.sv ====
// Behavioural codec in serial mode zero with a free running bit clock
`default_nettype none
module vcsc_codec_model #(
	parameter int FRAME_BITS = 40 // Short frame keeps the run brief
) (
	// Link pins
	output var logic        bit_clk,
	output var logic        frame_sync_n,
	output var logic        data_to_ctrl,
	input  wire logic       data_from_ctrl,
	// Bench side
	input  wire logic [15:0] send_word,
	output var logic [15:0] got_word
);
	timeunit 1ns;
	timeprecision 1ps;
	int          pos = FRAME_BITS - 1; // Bit position in frame
	logic [15:0] shift_in;             // Word from the controller
	initial begin
		bit_clk = 1'b0;
		frame_sync_n = 1'b1;
		data_to_ctrl = 1'b0;
		got_word = 16'h0000;
	end
	// Bit clock runs free, 80 ns period
	always #40 bit_clk = ~bit_clk;
	// Launch on the falling edge so the controller samples mid-bit
	always @(negedge bit_clk) begin
		if (pos < 16) begin
			shift_in = {shift_in[14:0], data_from_ctrl};
			if (pos == 15) got_word = shift_in;
		end
		pos = (pos + 1) % FRAME_BITS;
		frame_sync_n <= (pos >= 16);
		// Idle line shows the inverse of the last bit, never a stale value
		data_to_ctrl <= (pos < 16) ? send_word[15 - pos] : ~data_to_ctrl;
	end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench of the voice codec serial core against a codec model
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import vcsc_pkg::*;
	// ****************************************
	// Stimulus, observation and bookkeeping
	// ****************************************
	logic sys_clk = 1'b0, reset_n = 1'b0, sync_reset = 1'b0;
	logic mclk_enable = 1'b1, codec_enable = 1'b1, write_valid = 1'b0;
	logic [15:0] write_data = 16'h0000, send_word = 16'h0000;
	logic write_ready, write_data_grasp, write_busy, read_valid, done;
	logic sample_irq, ser_in, ser_out, bclk, fsn, mclk, fsync_out, prev;
	logic [15:0] read_data, got_word;
	logic [2:0] fs_hist;
	int failures = 0, check_count = 0, cyc = 0, n;
	// Rows: host word out, codec word in; LSB flag words included
	logic [15:0] rows [4][2] = '{'{16'h8001, 16'hFFFF}, '{16'h7FFE, 16'h8000},
		'{16'hA5A4, 16'h3C5A}, '{16'h0000, 16'h0001}};
	always #5 sys_clk = ~sys_clk;
	vcsc_core vcsc_core_inst (.sys_clk(sys_clk), .reset_n(reset_n),
		.sync_reset(sync_reset), .mclk_enable(mclk_enable),
		.codec_enable(codec_enable), .write_data(write_data),
		.write_valid(write_valid), .write_ready(write_ready),
		.write_data_grasp(write_data_grasp), .write_busy(write_busy),
		.read_data(read_data), .read_valid(read_valid), .done(done),
		.sample_irq(sample_irq), .codec_serial_in_pin(ser_in),
		.codec_serial_out_pin(ser_out), .codec_bit_clock_pin(bclk),
		.codec_frame_sync_pin(fsn), .codec_master_clock_pin(mclk),
		.fsync_out(fsync_out));
	vcsc_codec_model #(.FRAME_BITS(40)) vcsc_codec_model_inst (.bit_clk(bclk),
		.frame_sync_n(fsn), .data_to_ctrl(ser_in), .data_from_ctrl(ser_out),
		.send_word(send_word), .got_word(got_word));
	// ****************************************
	// Checks, waits and closing
	// ****************************************
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Bounded wait for a receive or a grasp pulse
	task automatic wait_evt(input bit rd);
		for (int k = 0; k < 3000; k++) begin
			@(posedge sys_clk);
			if ((rd ? read_valid : write_data_grasp) === 1'b1) return;
		end
		chk1(1'b0, 1'b1);
	endtask
	// Hold the offer until ready is sampled high
	task automatic host_write(input logic [15:0] w);
		write_data <= w;
		write_valid <= 1'b1;
		do @(posedge sys_clk); while (write_ready !== 1'b1);
		write_valid <= 1'b0;
	endtask
	// Hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			chk1(1'b0, 1'b1);
			tally_and_finish;
		end
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (200) @(posedge sys_clk); // Let the link hold lapse
		for (int i = 0; i < 4; i++) begin
			wait_evt(1'b1);
			send_word <= rows[i][1];
			host_write(rows[i][0]);
			wait_evt(1'b0);
			chk1(sample_irq, 1'b1);
			repeat (10) @(posedge sys_clk);
			chk16(got_word, rows[i][0]);
			chk1(write_busy, 1'b0);
			wait_evt(1'b1);
			chk16(read_data, rows[i][1]);
			chk1(done, 1'b1);
			chk1(sample_irq, 1'b1);
		end
		// Frame sync copy and master clock rate, sampled after each edge
		n = 0;
		for (int k = 0; k <= 250; k++) begin
			@(posedge sys_clk);
			#1;
			fs_hist = {fs_hist[1:0], fsn};
			if (k > 2) chk1(fsync_out, fs_hist[2]);
			if (k > 0 && mclk && !prev) n++;
			prev = mclk;
		end
		chk16(16'(n), 16'h000A);
		@(posedge sys_clk);
		mclk_enable <= 1'b0;
		repeat (3) @(posedge sys_clk);
		repeat (60) @(posedge sys_clk) chk1(mclk, 1'b0);
		mclk_enable <= 1'b1;
		// Reset must clear without waiting for an edge
		reset_n <= 1'b0;
		#1;
		chk16(read_data, 16'h0000);
		chk1(fsync_out, 1'b1);
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		codec_enable <= 1'b0;
		// Fill the buffer with the link held until it refuses
		repeat (3) @(posedge sys_clk);
		n = 0;
		write_valid <= 1'b1;
		repeat (12) begin
			@(posedge sys_clk);
			if (write_ready === 1'b1) n++;
		end
		write_valid <= 1'b0;
		chk1(n == 8, 1'b1);
		chk1(write_ready, 1'b0);
		// Synchronous reset empties the buffer and stops the clock
		sync_reset <= 1'b1;
		codec_enable <= 1'b1; // Clock would start here unless the reset stops it
		@(posedge sys_clk);
		sync_reset <= 1'b0;
		@(posedge sys_clk);
		chk1(write_ready, 1'b0);
		chk1(write_busy, 1'b0);
		chk1(mclk, 1'b0);
		repeat (2) @(posedge sys_clk);
		chk1(write_ready, 1'b1);
		tally_and_finish;
	end
endmodule
`default_nettype wire
